// ==== hw/kcv_params.svh ====
// Constants of the keyed clock and voltage register bank.
// Assumes inclusion by its bare name from the package, the register bank, the checker and the bench.
`ifndef KCV_PARAMS_SVH
`define KCV_PARAMS_SVH

// ****************************************************************
// Byte offsets
// ****************************************************************
`define KCV_OFF_CLK_EN   12'h0f8
`define KCV_OFF_UNIT_RST 12'h0fc
`define KCV_OFF_KEY      12'h100
`define KCV_OFF_DSV      12'h134
`define KCV_OFF_PDSEL    12'h138

// ****************************************************************
// Fields, values and reset values
// ****************************************************************
`define KCV_UNLOCK_VALUE 32'h1a2b3c4d
`define KCV_DSV_MSB      2
`define KCV_RESET_WORD   32'h00000000
`define KCV_RESP_OKAY    2'h0
`define KCV_RESP_SLVERR  2'h2

`endif

// ==== hw/kcv_pkg.sv ====
// Types of the keyed clock and voltage register bank.
// Assumes kcv_params.svh on the include path.
`include "kcv_params.svh"

package kcv_pkg;

    typedef enum logic [1:0]
    {
        KCV_WR_IDLE = 2'b01,
        KCV_WR_RESP = 2'b10
    } kcv_wr_state_t;

    typedef struct packed
    {
        logic [31:0] data;
        logic        unlocked;
    } kcv_key_t;

endpackage

// ==== hw/kcv_byte_merge.sv ====
// Byte-lane merge of a write word into a stored word.
// Assumes AXI4-Lite write strobes, one per byte lane.
`timescale 1ns/10ps

module kcv_byte_merge
(
    // Operands
    input  wire logic [31:0] old_in,
    input  wire logic [31:0] new_in,
    input  wire logic [3:0]  strb_in,
    // Result
    output logic      [31:0] merged_out
);

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign merged_out[8*g+7:8*g] =
                strb_in[g] ? new_in[8*g+7:8*g] : old_in[8*g+7:8*g];
        end
    endgenerate

endmodule // kcv_byte_merge

// ==== hw/kcv_regs.sv ====
// Keyed clock and voltage register bank behind an AXI4-Lite slave.
// Assumes one synchronous clock and a synchronous active-high reset.
//
// Behaviour
// - Clock-enable bit 0 gates third I2C clock; software sets and clears.
// - Reset bit 0 holds third I2C unit in reset while one.
// - Key register is write-only and always reads zero.
// - Voltage registers writable only after key 0x1A2B3C4D was written.
// - Deep-sleep code bits 2:0: 1.2V, 1.1V, 1.0V, 0.9V; rest reserved.
// - Power-down select bit 0: zero 2.6V, one 1.8V.
// - Registers other than the key accept byte, half-word and word writes; the key needs a full word.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "kcv_params.svh"

module kcv_regs
    import kcv_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // AXI4-Lite write address
    input  wire logic [11:0] awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    // AXI4-Lite write response
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    // AXI4-Lite read address
    input  wire logic [11:0] araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    // AXI4-Lite read data
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    // Controls
    output logic             third_i2c_clock_gate_out,
    output logic             third_i2c_reset_hold_out,
    output logic [2:0]       deep_sleep_voltage_code_out,
    output logic             power_down_level_select_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        kcv_wr_state_t wst;
        logic          aw_have;
        logic [11:0]   aw_addr;
        logic          w_have;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic          clk_en;
        logic          unit_rst;
        logic          unlocked;
        logic [2:0]    dsv;
        logic          pdsel;
        logic          aw_free;
        logic          w_free;
        logic          ar_free;
        logic          bvalid;
    } kcv_state_t;

    kcv_state_t  st_q;
    kcv_state_t  st_d;
    logic [31:0] old_word;
    logic [31:0] merged;
    logic        do_write;
    logic        do_read;

    kcv_byte_merge u_merge
    (
        .old_in     (old_word),
        .new_in     (st_q.w_data),
        .strb_in    (st_q.w_strb),
        .merged_out (merged)
    );

    // ****************************************************************
    // Old word under the write lane merge
    // ****************************************************************
    always_comb
    begin
        case (st_q.aw_addr)
            `KCV_OFF_CLK_EN:   old_word = {31'h0, st_q.clk_en};
            `KCV_OFF_UNIT_RST: old_word = {31'h0, st_q.unit_rst};
            `KCV_OFF_DSV:      old_word = {29'h0, st_q.dsv};
            `KCV_OFF_PDSEL:    old_word = {31'h0, st_q.pdsel};
            default:           old_word = `KCV_RESET_WORD;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        do_write = (st_q.wst == KCV_WR_IDLE) && st_q.aw_have && st_q.w_have;
        do_read = arvalid_in && !st_q.rvalid;
        if (!st_q.aw_have && awvalid_in)
        begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = {awaddr_in[11:2], 2'b00};
        end
        if (!st_q.w_have && wvalid_in)
        begin
            st_d.w_have = 1'b1;
            st_d.w_data = wdata_in;
            st_d.w_strb = wstrb_in;
        end
        case (st_q.wst)
            KCV_WR_IDLE:
            begin
                if (do_write)
                begin
                    st_d.wst = KCV_WR_RESP;
                    st_d.bresp = `KCV_RESP_OKAY;
                    case (st_q.aw_addr)
                        `KCV_OFF_CLK_EN:
                            st_d.clk_en = merged[0];
                        `KCV_OFF_UNIT_RST:
                            st_d.unit_rst = merged[0];
                        `KCV_OFF_KEY:
                            // Partial writes cannot form the key
                            st_d.unlocked = (st_q.w_strb == 4'hf) &&
                                (st_q.w_data == `KCV_UNLOCK_VALUE);
                        `KCV_OFF_DSV:
                        begin
                            if (st_q.unlocked)
                                st_d.dsv = merged[`KCV_DSV_MSB:0];
                        end
                        `KCV_OFF_PDSEL:
                        begin
                            if (st_q.unlocked)
                                st_d.pdsel = merged[0];
                        end
                        default:
                            st_d.bresp = `KCV_RESP_SLVERR;
                    endcase
                end
            end
            KCV_WR_RESP:
            begin
                if (bready_in)
                begin
                    st_d.wst = KCV_WR_IDLE;
                    st_d.aw_have = 1'b0;
                    st_d.w_have = 1'b0;
                end
            end
            default:
                st_d.wst = KCV_WR_IDLE;
        endcase
        if (st_q.rvalid && rready_in)
            st_d.rvalid = 1'b0;
        if (do_read)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `KCV_RESP_OKAY;
            case ({araddr_in[11:2], 2'b00})
                `KCV_OFF_CLK_EN:   st_d.rdata = {31'h0, st_q.clk_en};
                `KCV_OFF_UNIT_RST: st_d.rdata = {31'h0, st_q.unit_rst};
                `KCV_OFF_KEY:      st_d.rdata = `KCV_RESET_WORD;
                `KCV_OFF_DSV:      st_d.rdata = {29'h0, st_q.dsv};
                `KCV_OFF_PDSEL:    st_d.rdata = {31'h0, st_q.pdsel};
                default:
                begin
                    st_d.rdata = `KCV_RESET_WORD;
                    st_d.rresp = `KCV_RESP_SLVERR;
                end
            endcase
        end

        // ****************************************************************
        // Handshake outputs registered from the next state
        // ****************************************************************
        st_d.aw_free = !st_d.aw_have;
        st_d.w_free = !st_d.w_have;
        st_d.ar_free = !st_d.rvalid;
        st_d.bvalid = (st_d.wst == KCV_WR_RESP);
        if (rst_in)
        begin
            st_d = '0;
            st_d.wst = KCV_WR_IDLE;
            st_d.aw_free = 1'b1;
            st_d.w_free = 1'b1;
            st_d.ar_free = 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        st_q <= st_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign awready_out = st_q.aw_free;
    assign wready_out = st_q.w_free;
    assign bvalid_out = st_q.bvalid;
    assign bresp_out = st_q.bresp;
    assign arready_out = st_q.ar_free;
    assign rvalid_out = st_q.rvalid;
    assign rdata_out = st_q.rdata;
    assign rresp_out = st_q.rresp;
    assign third_i2c_clock_gate_out = st_q.clk_en;
    assign third_i2c_reset_hold_out = st_q.unit_rst;
    assign deep_sleep_voltage_code_out = st_q.dsv;
    assign power_down_level_select_out = st_q.pdsel;

endmodule // kcv_regs

// ==== test/kcv_regs_props.sv ====
// Port checker of the keyed clock and voltage register bank.
// Assumes binding to kcv_regs; one clock, synchronous reset.
`timescale 1ns/10ps
`include "kcv_params.svh"

module kcv_regs_props
(
    // Clock and reset
    input logic        mclk_in,
    input logic        rst_in,
    // Handshakes
    input logic        awvalid_in,
    input logic        awready_out,
    input logic        wvalid_in,
    input logic        wready_out,
    input logic        bvalid_out,
    input logic        bready_in,
    input logic        arvalid_in,
    input logic        arready_out,
    input logic        rvalid_out,
    input logic        rready_in,
    // Payloads
    input logic [1:0]  bresp_out,
    input logic [11:0] araddr_in,
    input logic [31:0] rdata_out,
    // Controls
    input logic        third_i2c_clock_gate_out,
    input logic        third_i2c_reset_hold_out,
    input logic [2:0]  deep_sleep_voltage_code_out,
    input logic        power_down_level_select_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_wlat;
        awvalid_in && awready_out && wvalid_in && wready_out
        |=> !awready_out ##1 bvalid_out;
    endproperty
    a_wlat: assert property (p_wlat) else $error("late write");
    property p_bhold;
        bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out);
    endproperty
    a_bhold: assert property (p_bhold) else $error("b lost");
    property p_rlat;
        arvalid_in && arready_out |=> rvalid_out && !arready_out;
    endproperty
    a_rlat: assert property (p_rlat) else $error("late read");
    property p_key;
        arvalid_in && arready_out && araddr_in == `KCV_OFF_KEY
        |=> rdata_out == 32'h0 throughout rvalid_out[*2];
    endproperty
    a_key: assert property (p_key) else $error("key read");
    property p_rsv;
        rvalid_out |-> rdata_out[31:3] == 29'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_gate;
        $changed(third_i2c_clock_gate_out) |-> $rose(bvalid_out);
    endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_hold;
        $changed(third_i2c_reset_hold_out) |-> $rose(bvalid_out);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_dsv;
        $changed(deep_sleep_voltage_code_out) |-> $rose(bvalid_out);
    endproperty
    a_dsv: assert property (p_dsv) else $error("dsv");
    property p_pd;
        $changed(power_down_level_select_out) |-> $rose(bvalid_out);
    endproperty
    a_pd: assert property (p_pd) else $error("pd");

    c_pd: cover property ($rose(power_down_level_select_out));
    c_gate: cover property ($rose(third_i2c_clock_gate_out));
    c_err: cover property (bvalid_out && bresp_out == `KCV_RESP_SLVERR);
endmodule // kcv_regs_props

bind kcv_regs kcv_regs_props u_props (.*);

// ==== test/kcv_regs_test.sv ====
// Self-checking bench of the keyed clock and voltage register bank.
// Assumes the checker file is compiled alongside.
`timescale 1ns/10ps
`include "kcv_params.svh"

module kcv_regs_test;
    localparam logic [1:0] ok_r = `KCV_RESP_OKAY;
    localparam logic [1:0] err_r = `KCV_RESP_SLVERR;
    logic        mclk_in = 0, rst_in = 1;
    logic [11:0] awaddr_in = 0, araddr_in = 0;
    logic [31:0] wdata_in = 0, rdata_out;
    logic [3:0]  wstrb_in = 0;
    logic        awvalid_in = 0, wvalid_in = 0, bready_in = 0;
    logic        arvalid_in = 0, rready_in = 0;
    logic        awready_out, wready_out, bvalid_out, arready_out;
    logic        rvalid_out, power_down_level_select_out;
    logic [1:0]  bresp_out, rresp_out;
    logic        third_i2c_clock_gate_out, third_i2c_reset_hold_out;
    logic [2:0]  deep_sleep_voltage_code_out;
    int          num_errors = 0, checks_done = 0;

    kcv_regs u_dut (.*);

    always #20 mclk_in = ~mclk_in;

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            num_errors++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int   n;
        logic ta, tw;
        awaddr_in <= a;
        wdata_in <= d;
        wstrb_in <= s;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge mclk_in);
            if (bvalid_out === 1'b1 && bready_in)
                break;
            ta = awvalid_in & awready_out;
            tw = wvalid_in & wready_out;
            @(posedge mclk_in);
            awvalid_in <= awvalid_in & !ta;
            wvalid_in <= wvalid_in & !tw;
            bready_in <= (n >= 2);
        end
        tmo(n);
        chk({30'h0, bresp_out}, {30'h0, er});
        @(posedge mclk_in);
        bready_in <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int   n;
        logic t;
        araddr_in <= a;
        arvalid_in <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge mclk_in);
            if (rvalid_out === 1'b1 && rready_in)
                break;
            t = arvalid_in & arready_out;
            @(posedge mclk_in);
            arvalid_in <= arvalid_in & !t;
            rready_in <= (n >= 1);
        end
        tmo(n);
        chk(rdata_out, ed);
        chk({30'h0, rresp_out}, {30'h0, er});
        @(posedge mclk_in);
        rready_in <= 1'b0;
    endtask

    task automatic t_gate;
        wr(`KCV_OFF_CLK_EN, 32'h1, 4'h1, ok_r);
        chk({31'h0, third_i2c_clock_gate_out}, 32'h1);
        rd(`KCV_OFF_CLK_EN, 32'h1, ok_r);
        wr(`KCV_OFF_CLK_EN, 32'h0, 4'he, ok_r);
        chk({31'h0, third_i2c_clock_gate_out}, 32'h1);
        wr(`KCV_OFF_UNIT_RST, 32'h1, 4'h3, ok_r);
        chk({31'h0, third_i2c_reset_hold_out}, 32'h1);
        wr(`KCV_OFF_CLK_EN, 32'h0, 4'hf, ok_r);
        wr(`KCV_OFF_UNIT_RST, 32'h0, 4'hf, ok_r);
        chk({30'h0, third_i2c_clock_gate_out,
             third_i2c_reset_hold_out}, 32'h0);
        $display("gate test done");
    endtask

    task automatic t_key;
        wr(`KCV_OFF_DSV, 32'h3, 4'hf, ok_r);
        chk({29'h0, deep_sleep_voltage_code_out}, 32'h0);
        wr(`KCV_OFF_KEY, `KCV_UNLOCK_VALUE, 4'hf, ok_r);
        rd(`KCV_OFF_KEY, 32'h0, ok_r);
        for (int c = 0; c < 4; c++)
        begin
            wr(`KCV_OFF_DSV, 32'(c), 4'h1, ok_r);
            chk({29'h0, deep_sleep_voltage_code_out}, 32'(c));
        end
        rd(`KCV_OFF_DSV, 32'h3, ok_r);
        wr(`KCV_OFF_PDSEL, 32'h1, 4'h1, ok_r);
        chk({31'h0, power_down_level_select_out}, 32'h1);
        wr(`KCV_OFF_PDSEL, 32'h0, 4'h3, ok_r);
        chk({31'h0, power_down_level_select_out}, 32'h0);
        wr(`KCV_OFF_KEY, 32'h1a2b3c4c, 4'hf, ok_r);
        wr(`KCV_OFF_PDSEL, 32'h1, 4'hf, ok_r);
        wr(`KCV_OFF_DSV, 32'h1, 4'hf, ok_r);
        chk({28'h0, power_down_level_select_out,
             deep_sleep_voltage_code_out}, 32'h3);
        wr(`KCV_OFF_KEY, `KCV_UNLOCK_VALUE, 4'hf, ok_r);
        wr(`KCV_OFF_KEY, `KCV_UNLOCK_VALUE, 4'h7, ok_r);
        wr(`KCV_OFF_PDSEL, 32'h1, 4'hf, ok_r);
        chk({31'h0, power_down_level_select_out}, 32'h0);
        wr(12'h0f4, 32'h1, 4'hf, err_r);
        rd(12'h0f4, 32'h0, err_r);
        $display("key test done");
    endtask

    initial
    begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(`KCV_OFF_PDSEL, `KCV_RESET_WORD, ok_r);
        t_gate();
        t_key();
        wrap_up();
    end
endmodule // kcv_regs_test
